// ### core/mmam_pkg.sv
// Constants and types shared by the memory address map block
package mmam_pkg;
	// Program side widths and vectors
	localparam int PC_W = 11;
	localparam int SHORT_W = 8;
	localparam logic [10:0] RESET_VEC = 11'h000;
	localparam logic [10:0] SOFT_INT_VEC = 11'h001;
	localparam logic [10:0] HW_INT_VEC = 11'h008;
	localparam logic [10:0] RESV_LO = 11'h7FE;
	localparam logic [10:0] RESV_HI = 11'h7FF;
	localparam logic [10:0] ROLL_LO = 11'h00E;
	localparam logic [10:0] ROLL_HI = 11'h00F;
	localparam logic [10:0] PC_STEP = 11'h001;
	// Return stack shape
	localparam int STACK_DEPTH = 8;
	localparam int STACK_PTR_W = 3;
	localparam logic [2:0] STACK_PTR_RST = 3'h0;
	localparam logic [2:0] STACK_PTR_STEP = 3'h1;
	// Data side layout
	localparam int DADDR_W = 7;
	localparam int BANK_HI = 7;
	localparam int BANK_LO = 6;
	localparam logic [6:0] INDIRECT_LOC = 7'h00;
	localparam logic [6:0] SFR_TOP = 7'h1F;
	localparam logic [6:0] GPR_LO_TOP = 7'h3F;
	localparam logic [6:0] DADDR_RST = 7'h00;
	// Program counter operations requested by the execute logic
	typedef enum logic [3:0] {
		PC_SEQ,
		PC_HOLD,
		PC_SHORT_JUMP,
		PC_SHORT_CALL,
		PC_LONG_JUMP,
		PC_LONG_CALL,
		PC_PLAIN_RET,
		PC_RET_LIT,
		PC_RET_INT,
		PC_SOFT_INT,
		PC_HW_INT
	} mmam_pc_op_type;
	// Data access kinds
	typedef enum logic [2:0] {
		ACC_NONE,
		ACC_GENERAL,
		ACC_SECOND_WR,
		ACC_SECOND_RD,
		ACC_THIRD_WR,
		ACC_THIRD_RD
	} mmam_acc_type;
	// Region that a decoded access lands in
	typedef enum logic [2:0] {
		REG_IDLE,
		REG_GEN_SFR,
		REG_GPR,
		REG_SECOND,
		REG_THIRD
	} mmam_region_type;
endpackage

// ### core/mmam_stack_if.sv
// Push and pop channel between the address map and its return stack
`timescale 1ns/1ns
`default_nettype none
interface mmam_stack_if;
	import mmam_pkg::*;
	logic push; // Store push_data as new top
	logic pop; // Drop the top entry
	logic [PC_W-1:0] push_data; // Return address to store
	logic [PC_W-1:0] top; // Current top entry
	modport ctrl (output push, output pop, output push_data, input top);
	modport store (input push, input pop, input push_data, output top);
endinterface
`default_nettype wire

// ### core/mmam_ret_stack.sv
// Eight entry return address stack
`timescale 1ns/1ns
`default_nettype none
module mmam_ret_stack
	import mmam_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	mmam_stack_if.store stk
);
	// Entry storage, kept until overwritten by a later push
	logic [PC_W-1:0] mem [STACK_DEPTH];
	// Points at the next free slot; wraps after eight pushes
	logic [STACK_PTR_W-1:0] ptr;

	// Pointer moves up on push, down on pop
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			ptr <= STACK_PTR_RST;
		end else if (stk.push) begin
			ptr <= ptr + STACK_PTR_STEP;
		end else if (stk.pop) begin
			ptr <= ptr - STACK_PTR_STEP;
		end
	end

	// Only the pushed slot is written; pops leave contents alone
	always_ff @(posedge sys_clk_i) begin
		if (stk.push) begin
			mem[ptr] <= stk.push_data;
		end
	end

	// Top is the slot just below the free pointer
	assign stk.top = mem[ptr - STACK_PTR_STEP];

	a_pop_restores: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		stk.push && !stk.pop ##1 !stk.push && !stk.pop ##1 stk.pop
		|-> stk.top == $past(stk.push_data, 2))
		else $error("stack top changed without a push");
endmodule // mmam_ret_stack
`default_nettype wire

// ### core/mmam_addr_map.sv
// Program counter and data address mapping for the core
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Program counter is eleven bits wide
// - Reset loads program counter with zero
// - Software interrupt jumps to address one
// - Hardware interrupts share vector at eight
// - Short jump and call reach 256 words
// - Long jump and call reach everything
// - Calls and interrupts push next address
// - All three returns pop top into counter
// - Rolling code words double as program space
// - Four banks chosen by status bits 7:6
// - Indirect access uses bank and pointer bits
// - Direct access uses bank and opcode bits
// - Special registers live only in bank zero
// - RAM at bank0 20-7F, bank1 20-3F
// - Other pages need their own instructions
// - Other pages ignore bank select bits
module mmam_addr_map
	import mmam_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire mmam_pc_op_type pc_op_i,
	input wire logic [SHORT_W-1:0] short_target_i,
	input wire logic [PC_W-1:0] long_target_i,
	input wire mmam_acc_type acc_i,
	input wire logic [DADDR_W-1:0] opcode_addr_i,
	input wire logic [7:0] status_i,
	input wire logic [7:0] file_pointer_register_i,
	output logic [PC_W-1:0] pc_o,
	output logic reserved_fetch_o,
	output logic rolling_code_fetch_o,
	output mmam_region_type region_o,
	output logic phys_bank_o,
	output logic [DADDR_W-1:0] data_addr_o,
	output logic data_write_o
);
	// Stack channel
	mmam_stack_if stk ();
	// Address of the word after the current one
	logic [PC_W-1:0] pc_next_seq;
	// Counter value for the following cycle
	logic [PC_W-1:0] next_pc;
	// Bank select field of the status register
	logic [1:0] bank_select_bits;
	// Location after indirect substitution
	logic [DADDR_W-1:0] eff_loc;
	// Decode for the following cycle
	mmam_region_type next_region;
	logic next_bank;
	logic next_write;

	// Fold a general page bank and location onto the physical bank
	function automatic logic fold_bank(input logic [1:0] bank,
		input logic [DADDR_W-1:0] loc);
		logic res;
		res = 1'b0;
		if (loc > SFR_TOP && loc <= GPR_LO_TOP) begin
			res = bank[0];
		end
		return res;
	endfunction

	mmam_ret_stack u_stack (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.stk(stk)
	);

	assign pc_next_seq = pc_o + PC_STEP;

	// Next program counter from the requested operation
	always_comb begin
		next_pc = pc_next_seq;
		unique case (pc_op_i)
			PC_SEQ: next_pc = pc_next_seq;
			PC_HOLD: next_pc = pc_o;
			// Short forms stay inside the current 256-word page
			PC_SHORT_JUMP, PC_SHORT_CALL: begin
				next_pc = {pc_o[PC_W-1:SHORT_W], short_target_i};
			end
			PC_LONG_JUMP, PC_LONG_CALL: next_pc = long_target_i;
			PC_PLAIN_RET, PC_RET_LIT, PC_RET_INT: begin
				next_pc = stk.top;
			end
			PC_SOFT_INT: next_pc = SOFT_INT_VEC;
			PC_HW_INT: next_pc = HW_INT_VEC;
			default: next_pc = pc_next_seq;
		endcase
	end

	// Program counter register, eleven bits covering 2K words
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			pc_o <= RESET_VEC;
		end else begin
			pc_o <= next_pc;
		end
	end

	// Push the return address on calls and interrupts
	always_comb begin
		stk.push = nrst_i && (pc_op_i == PC_SHORT_CALL
			|| pc_op_i == PC_LONG_CALL || pc_op_i == PC_SOFT_INT
			|| pc_op_i == PC_HW_INT);
		stk.pop = nrst_i && (pc_op_i == PC_PLAIN_RET
			|| pc_op_i == PC_RET_LIT || pc_op_i == PC_RET_INT);
		stk.push_data = pc_next_seq;
	end

	// Flags for fetches from the reserved and rolling code words
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			reserved_fetch_o <= 1'b0;
			rolling_code_fetch_o <= 1'b0;
		end else begin
			reserved_fetch_o <= next_pc >= RESV_LO
				&& next_pc <= RESV_HI;
			// Fetch proceeds normally; the flag only reports it
			rolling_code_fetch_o <= next_pc >= ROLL_LO
				&& next_pc <= ROLL_HI;
		end
	end

	assign bank_select_bits = status_i[BANK_HI:BANK_LO];

	// Indirect register replaced by the pointer location
	always_comb begin
		if (opcode_addr_i == INDIRECT_LOC) begin
			eff_loc = file_pointer_register_i[DADDR_W-1:0];
		end else begin
			eff_loc = opcode_addr_i;
		end
	end

	// Region, bank and write decode for the following cycle
	always_comb begin
		next_region = REG_IDLE;
		next_bank = 1'b0;
		next_write = 1'b0;
		unique case (acc_i)
			ACC_NONE: next_region = REG_IDLE;
			ACC_GENERAL: begin
				if (eff_loc <= SFR_TOP) begin
					next_region = REG_GEN_SFR;
				end else begin
					next_region = REG_GPR;
				end
				next_bank = fold_bank(bank_select_bits, eff_loc);
			end
			// Side pages: bank bits play no part
			ACC_SECOND_WR, ACC_SECOND_RD: begin
				next_region = REG_SECOND;
				next_write = acc_i == ACC_SECOND_WR;
			end
			ACC_THIRD_WR, ACC_THIRD_RD: begin
				next_region = REG_THIRD;
				next_write = acc_i == ACC_THIRD_WR;
			end
			default: next_region = REG_IDLE;
		endcase
	end

	// Registered data side outputs
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			region_o <= REG_IDLE;
			phys_bank_o <= 1'b0;
			data_addr_o <= DADDR_RST;
			data_write_o <= 1'b0;
		end else begin
			region_o <= next_region;
			phys_bank_o <= next_bank;
			// General page takes the substituted location, side pages the opcode
			if (acc_i == ACC_GENERAL) begin
				data_addr_o <= eff_loc;
			end else begin
				data_addr_o <= opcode_addr_i;
			end
			data_write_o <= next_write;
		end
	end

	// Sequences for call and return
	sequence s_call;
		pc_op_i == PC_LONG_CALL || pc_op_i == PC_SHORT_CALL;
	endsequence
	sequence s_ret;
		pc_op_i == PC_PLAIN_RET || pc_op_i == PC_RET_LIT
			|| pc_op_i == PC_RET_INT;
	endsequence

	a_reset_vector: assert property (@(posedge sys_clk_i)
		!nrst_i |=> pc_o == RESET_VEC)
		else $error("pc not at reset vector");
	a_soft_vector: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		pc_op_i == PC_SOFT_INT |=> pc_o == SOFT_INT_VEC)
		else $error("software interrupt vector wrong");
	a_hw_vector: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		pc_op_i == PC_HW_INT |=> pc_o == HW_INT_VEC)
		else $error("hardware interrupt vector wrong");
	a_short_reach: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		pc_op_i == PC_SHORT_JUMP |=> pc_o[10:8] == $past(pc_o[10:8])
		&& pc_o[7:0] == $past(short_target_i))
		else $error("short jump left its page");
	a_long_reach: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		pc_op_i == PC_LONG_JUMP |=> pc_o == $past(long_target_i))
		else $error("long jump target wrong");
	a_call_return: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_call ##1 (pc_op_i == PC_SEQ) ##1 s_ret
		|=> pc_o == $past(pc_o, 3) + PC_STEP)
		else $error("return did not resume after call");
	a_bank_select: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		acc_i == ACC_GENERAL && opcode_addr_i == 7'h25
		&& status_i[7:6] == 2'h3 |=> phys_bank_o && region_o == REG_GPR)
		else $error("bank three did not fold to bank one");
	a_sfr_bank0: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		acc_i == ACC_GENERAL && eff_loc <= SFR_TOP
		|=> !phys_bank_o && region_o == REG_GEN_SFR)
		else $error("special register outside bank zero");
	a_indirect_loc: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		acc_i == ACC_GENERAL && opcode_addr_i == INDIRECT_LOC
		|=> data_addr_o == $past(file_pointer_register_i[6:0]))
		else $error("indirect access not redirected");
	a_upper_gpr: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		acc_i == ACC_GENERAL && opcode_addr_i > GPR_LO_TOP
		|=> !phys_bank_o && data_addr_o == $past(opcode_addr_i))
		else $error("upper ram not in bank zero");
	a_side_pages: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		acc_i == ACC_THIRD_WR |=> region_o == REG_THIRD && data_write_o
		&& !phys_bank_o)
		else $error("third page write misdecoded");
	a_roll_flag: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		pc_o == ROLL_LO |-> rolling_code_fetch_o)
		else $error("rolling code fetch not flagged");
endmodule // mmam_addr_map
`default_nettype wire

// ### test/mmam_cpu_model.sv
// Behavioural execute logic that feeds the address map
`timescale 1ns/1ns
`default_nettype none
module mmam_cpu_model
	import mmam_pkg::*;
(
	input wire logic sys_clk_i,
	output var mmam_pc_op_type pc_op_o,
	output var logic [SHORT_W-1:0] short_o,
	output var logic [PC_W-1:0] long_o,
	output var mmam_acc_type acc_o,
	output var logic [DADDR_W-1:0] opc_o,
	output var logic [7:0] status_o,
	output var logic [7:0] fp_o
);
	// Quiet values from time zero on
	initial begin
		pc_op_o = PC_HOLD;
		short_o = 8'h00;
		long_o = 11'h000;
		acc_o = ACC_NONE;
		opc_o = 7'h00;
		status_o = 8'h00;
		fp_o = 8'h00;
	end
	// One program operation per edge; never aims at the top two words
	task automatic pc(input mmam_pc_op_type op, input logic [7:0] st,
		input logic [10:0] lt);
		@(posedge sys_clk_i);
		pc_op_o <= op;
		short_o <= st;
		long_o <= lt;
		#1;
	endtask
	// One data access per edge
	task automatic dat(input mmam_acc_type acc, input logic [6:0] oa,
		input logic [7:0] st, input logic [7:0] fp);
		@(posedge sys_clk_i);
		acc_o <= acc;
		opc_o <= oa;
		status_o <= st;
		fp_o <= fp;
		#1;
	endtask
	// Idle cycle: hold the counter, no access
	task automatic tick();
		@(posedge sys_clk_i);
		pc_op_o <= PC_HOLD;
		acc_o <= ACC_NONE;
		#1;
	endtask
endmodule // mmam_cpu_model
`default_nettype wire

// ### test/mmam_addr_map_tb.sv
// Self-checking bench for the address map
`timescale 1ns/1ns
`default_nettype none
module mmam_addr_map_tb;
	import mmam_pkg::*;
	logic sys_clk_i; // Core clock
	logic nrst_i; // Synchronous reset, low active
	mmam_pc_op_type pc_op;
	logic [7:0] short_t;
	logic [10:0] long_t;
	mmam_acc_type acc;
	logic [6:0] opc;
	logic [7:0] status;
	logic [7:0] fp;
	logic [10:0] pc_o;
	logic resv;
	logic roll;
	mmam_region_type region;
	logic bank;
	logic [6:0] daddr;
	logic dwr;
	int fail_count = 0;
	int n_compared = 0;
	mmam_addr_map DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
		.pc_op_i(pc_op), .short_target_i(short_t), .long_target_i(long_t),
		.acc_i(acc), .opcode_addr_i(opc), .status_i(status),
		.file_pointer_register_i(fp), .pc_o(pc_o), .reserved_fetch_o(resv),
		.rolling_code_fetch_o(roll), .region_o(region), .phys_bank_o(bank),
		.data_addr_o(daddr), .data_write_o(dwr));
	mmam_cpu_model cpu (.sys_clk_i(sys_clk_i), .pc_op_o(pc_op),
		.short_o(short_t), .long_o(long_t), .acc_o(acc), .opc_o(opc),
		.status_o(status), .fp_o(fp));
	// Free running 100 ns clock
	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Program operation, then the counter it leaves
	task automatic pgo(input mmam_pc_op_type op, input logic [7:0] st,
		input logic [10:0] lt, input logic [10:0] exp);
		cpu.pc(op, st, lt);
		cpu.tick();
		chk({5'h00, pc_o}, {5'h00, exp});
	endtask
	// Data access, then the decoded place
	task automatic dgo(input mmam_acc_type a, input logic [6:0] oa,
		input logic [7:0] st, input logic [7:0] f, input mmam_region_type r,
		input logic b, input logic [6:0] ad, input logic w);
		cpu.dat(a, oa, st, f);
		cpu.tick();
		chk({4'h0, region, bank, daddr, dwr}, {4'h0, r, b, ad, w});
	endtask
	// Jumps, calls, vectors and flagged words
	task automatic t_jumps();
		pgo(PC_LONG_JUMP, 8'h00, 11'h534, 11'h534);
		pgo(PC_SHORT_CALL, 8'hAB, 11'h000, 11'h5AB);
		pgo(PC_PLAIN_RET, 8'h00, 11'h000, 11'h535);
		pgo(PC_SHORT_JUMP, 8'h12, 11'h000, 11'h512);
		pgo(PC_SOFT_INT, 8'h00, 11'h000, 11'h001);
		pgo(PC_RET_INT, 8'h00, 11'h000, 11'h513);
		pgo(PC_HW_INT, 8'h00, 11'h000, 11'h008);
		pgo(PC_RET_LIT, 8'h00, 11'h000, 11'h514);
		pgo(PC_LONG_JUMP, 8'h00, 11'h00E, 11'h00E);
		chk({15'h0000, roll}, 16'h0001);
		pgo(PC_SEQ, 8'h00, 11'h000, 11'h00F);
		pgo(PC_SEQ, 8'h00, 11'h000, 11'h010);
		chk({15'h0000, roll}, 16'h0000);
		pgo(PC_LONG_JUMP, 8'h00, 11'h7FD, 11'h7FD);
		chk({15'h0000, resv}, 16'h0000);
		$display("test jumps done");
	endtask
	// Eight nested calls unwound by all three returns
	task automatic t_stack();
		logic [10:0] ret;
		pgo(PC_LONG_JUMP, 8'h00, 11'h100, 11'h100);
		for (int i = 0; i < 8; i++) begin
			pgo(PC_LONG_CALL, 8'h00, 11'h200 + 11'(i * 16), 11'h200 + 11'(i * 16));
		end
		for (int i = 7; i >= 0; i--) begin
			ret = (i == 0) ? 11'h101 : 11'h201 + 11'((i - 1) * 16);
			pgo(mmam_pc_op_type'(PC_PLAIN_RET + (i % 3)), 8'h00, 11'h000, ret);
		end
		// Call, one plain step, then return, back to back with no idle
		cpu.pc(PC_LONG_CALL, 8'h00, 11'h300);
		cpu.pc(PC_SEQ, 8'h00, 11'h000);
		cpu.pc(PC_PLAIN_RET, 8'h00, 11'h000);
		cpu.tick();
		chk({5'h00, pc_o}, 16'h0102);
		$display("test stack done");
	endtask
	// Bank folding, indirect access and side pages
	task automatic t_data();
		dgo(ACC_GENERAL, 7'h25, 8'hDF, 8'h00, REG_GPR, 1'b1, 7'h25, 1'b0);
		dgo(ACC_GENERAL, 7'h25, 8'h80, 8'h00, REG_GPR, 1'b0, 7'h25, 1'b0);
		dgo(ACC_GENERAL, 7'h3F, 8'h40, 8'h00, REG_GPR, 1'b1, 7'h3F, 1'b0);
		dgo(ACC_GENERAL, 7'h40, 8'hC0, 8'h00, REG_GPR, 1'b0, 7'h40, 1'b0);
		dgo(ACC_GENERAL, 7'h1F, 8'hC0, 8'h00, REG_GEN_SFR, 1'b0, 7'h1F, 1'b0);
		dgo(ACC_GENERAL, 7'h00, 8'h40, 8'hB0, REG_GPR, 1'b1, 7'h30, 1'b0);
		dgo(ACC_GENERAL, 7'h00, 8'h00, 8'h7F, REG_GPR, 1'b0, 7'h7F, 1'b0);
		dgo(ACC_SECOND_WR, 7'h05, 8'hC0, 8'h00, REG_SECOND, 1'b0, 7'h05, 1'b1);
		dgo(ACC_SECOND_RD, 7'h0F, 8'h40, 8'h00, REG_SECOND, 1'b0, 7'h0F, 1'b0);
		dgo(ACC_THIRD_WR, 7'h15, 8'hC0, 8'h00, REG_THIRD, 1'b0, 7'h15, 1'b1);
		dgo(ACC_THIRD_RD, 7'h10, 8'h80, 8'h00, REG_THIRD, 1'b0, 7'h10, 1'b0);
		$display("test data done");
	endtask
	// Reset in mid run brings the counter home
	task automatic t_reset();
		@(posedge sys_clk_i);
		nrst_i <= 1'b0;
		@(posedge sys_clk_i);
		nrst_i <= 1'b1;
		#1;
		chk({5'h00, pc_o}, 16'h0000);
		chk({13'h0000, region}, {13'h0000, REG_IDLE});
		pgo(PC_SEQ, 8'h00, 11'h000, 11'h001);
		$display("test reset done");
	endtask
	// Counts and verdict, then stop
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		nrst_i = 1'b0;
		repeat (16) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		#1;
		chk({5'h00, pc_o}, 16'h0000);
		t_jumps();
		t_stack();
		t_data();
		t_reset();
		stop_test();
	end
	// Watchdog well past the 104 cycles needed
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		fail_count++;
		stop_test();
	end
endmodule // mmam_addr_map_tb
`default_nettype wire
